// [common/isp_pkg.sv]
// shared constants and types for the serial in-system programming host
package isp_pkg;

  // system clock rate
  localparam int SYS_CLK_MHZ = 200;
  localparam int SYS_CLK_KHZ = SYS_CLK_MHZ * 1000;

  // minimum waits, in their own units
  localparam int POWERUP_WAIT_MS = 20;
  localparam int FLASH_WAIT_US = 4500;
  localparam int EEPROM_WAIT_US = 3600;
  localparam int ERASE_WAIT_US = 9000;
  localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_MS * 1000 * SYS_CLK_MHZ;
  localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * SYS_CLK_MHZ;
  localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * SYS_CLK_MHZ;
  localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * SYS_CLK_MHZ;

  // device cpu clock phases per serial clock phase
  localparam int CPU_FAST_KHZ = 12000;
  localparam int CPU_PHASE_SLOW = 2;
  localparam int CPU_PHASE_FAST = 3;
  localparam int RST_PULSE_CPU_CYC = 2;

  // wait counter width and session retries
  localparam int WAIT_W = 24;
  localparam int RETRY_MAX = 3;

  // instruction bytes
  localparam logic [7:0] OPC_ENABLE = 8'hac;
  localparam logic [7:0] ENABLE_ECHO = 8'h53;
  localparam logic [7:0] OPC_ERASE_B2 = 8'h80;
  localparam logic [3:0] OPC_READ_FLASH = 4'h2;
  localparam logic [3:0] OPC_LOAD_PAGE = 4'h4;
  localparam logic [7:0] OPC_WRITE_PAGE = 8'h4c;
  localparam logic [7:0] OPC_READ_EE = 8'ha0;
  localparam logic [7:0] OPC_WRITE_EE = 8'hc0;
  localparam logic [7:0] OPC_POLL = 8'hf0;
  localparam logic [7:0] ALL_ONES = 8'hff;

  // address fields
  localparam int ADDR_W = 16;
  localparam int PAGE_WORD_W = 6;
  localparam int INSTR_W = 32;
  localparam int ECHO_LSB = 8;
  localparam int POLL_BUSY_BIT = 0;

  typedef enum logic [2:0] {
    OP_ERASE,
    OP_LOAD_PAGE,
    OP_WRITE_PAGE,
    OP_READ_FLASH,
    OP_READ_EE,
    OP_WRITE_EE,
    OP_POLL
  } isp_op_t;

endpackage

// [src/isp_programmer.sv]
// host controller for the serial in-system programming port
//
// Function
// - target reset held low during whole session
// - enable instruction precedes any other instruction
// - serial clock phases exceed device cpu limit below 12 MHz, meet it from 12 MHz
// - mosi stable across each serial clock rise
// - sck low, then reset pulsed two cpu cycles
// - wait 20 ms before enable instruction
// - send all four bytes, resync on bad echo
// - page load carries six word bits, data
// - low byte loaded before high byte
// - no access until page write completes
// - eeprom bytewise; skip ones after erase
// - reset high ends session, normal operation
// - all-ones page data uses full wait
// - timed waits 4.5, 3.6, 9.0 ms
// - enable is ac 53 then two bytes
`timescale 1ns/1ps
`default_nettype none
module isp_programmer
  import isp_pkg::*;
#(
  parameter int CPU_CLK_KHZ = 8000,
  parameter int POWERUP_CYC = POWERUP_WAIT_CYC,
  parameter int FLASH_CYC = FLASH_WAIT_CYC,
  parameter int EEPROM_CYC = EEPROM_WAIT_CYC,
  parameter int ERASE_CYC = ERASE_WAIT_CYC
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // session and command port
  input wire logic I_SESSION,
  input wire logic I_CMD_VALID,
  input wire isp_pkg::isp_op_t I_CMD_OP,
  input wire logic I_CMD_HIGH,
  input wire logic I_CMD_POLL,
  input wire logic [isp_pkg::ADDR_W-1:0] I_CMD_ADDR,
  input wire logic [7:0] I_CMD_DATA,
  output logic O_CMD_READY,
  output logic O_DONE,
  output logic O_REFUSED,
  output logic [7:0] O_RDATA,
  output logic O_SYNCED,
  output logic O_SYNC_FAIL,
  // target pins
  output logic O_DEV_RESET,
  output logic O_SCK,
  output logic O_MOSI,
  input wire logic I_MISO
);
  import isp_pkg::*;

  // --------------------------------------------------------------
  // timing derived from the device cpu clock
  // --------------------------------------------------------------
  localparam int CPU_PHASE = (CPU_CLK_KHZ < CPU_FAST_KHZ) ? CPU_PHASE_SLOW + 1 : CPU_PHASE_FAST;
  localparam int SCK_HALF = (CPU_PHASE * SYS_CLK_KHZ + CPU_CLK_KHZ - 1) / CPU_CLK_KHZ;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_CPU_CYC * SYS_CLK_KHZ + CPU_CLK_KHZ - 1) / CPU_CLK_KHZ;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RST_PULSE,
    ST_POWERUP,
    ST_ENABLE,
    ST_IDLE,
    ST_SHIFT,
    ST_POLL,
    ST_WAIT
  } state_t;

  state_t state;
  logic [WAIT_W-1:0] cnt;
  logic [WAIT_W-1:0] wait_tgt;
  logic [1:0] retry;
  isp_op_t op;
  logic use_poll;
  logic erased;
  logic low_loaded;
  logic [PAGE_WORD_W-1:0] low_addr;
  logic page_ones;
  logic shift_start;
  logic [INSTR_W-1:0] shift_tx;
  logic shift_busy;
  logic shift_done;
  logic [INSTR_W-1:0] shift_rx;
  logic miso_sync;
  logic accept;
  logic refuse;
  logic skip;

  // --------------------------------------------------------------
  // link
  // --------------------------------------------------------------
  isp_sync #(
    .W(1)
  ) u_miso_sync (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_d(I_MISO),
    .o_q(miso_sync)
  );

  // divided clock keeps each phase above the cpu minimum under 12 MHz, no shorter than it from 12 MHz
  isp_shifter #(
    .HALF(SCK_HALF)
  ) u_shifter (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_start(shift_start),
    .i_tx(shift_tx),
    .o_busy(shift_busy),
    .o_done(shift_done),
    .o_rx(shift_rx),
    .i_miso(miso_sync),
    .o_sck(O_SCK),
    .o_mosi(O_MOSI)
  );

  // --------------------------------------------------------------
  // instruction encoding
  // --------------------------------------------------------------
  function automatic logic [INSTR_W-1:0] encode(
    input isp_op_t f_op,
    input logic f_high,
    input logic [ADDR_W-1:0] f_addr,
    input logic [7:0] f_data
  );
    logic [INSTR_W-1:0] w;
    w = {OPC_POLL, 24'h0};
    case (f_op)
      OP_ERASE: w = {OPC_ENABLE, OPC_ERASE_B2, 16'h0};
      OP_LOAD_PAGE: w = {OPC_LOAD_PAGE, f_high, 3'h0, 8'h0, 2'h0,
                         f_addr[PAGE_WORD_W-1:0], f_data};
      OP_WRITE_PAGE: w = {OPC_WRITE_PAGE, 3'h0, f_addr[12:8], f_addr[7:6],
                          6'h0, 8'h0};
      OP_READ_FLASH: w = {OPC_READ_FLASH, f_high, 3'h0, 3'h0, f_addr[12:8],
                          f_addr[7:0], 8'h0};
      OP_READ_EE: w = {OPC_READ_EE, 6'h0, f_addr[9:8], f_addr[7:0], 8'h0};
      OP_WRITE_EE: w = {OPC_WRITE_EE, 6'h0, f_addr[9:8], f_addr[7:0], f_data};
      OP_POLL: w = {OPC_POLL, 24'h0};
      default: w = {OPC_POLL, 24'h0};
    endcase
    return w;
  endfunction

  // --------------------------------------------------------------
  // command acceptance
  // --------------------------------------------------------------
  assign O_CMD_READY = (state == ST_IDLE) && I_SESSION;
  assign accept = O_CMD_READY && I_CMD_VALID;
  // high byte without its low byte first would load a stale word
  assign refuse = (I_CMD_OP == OP_LOAD_PAGE) && I_CMD_HIGH &&
                  !(low_loaded && low_addr == I_CMD_ADDR[PAGE_WORD_W-1:0]);
  // erased array already holds all ones
  assign skip = (I_CMD_OP == OP_WRITE_EE) && erased && (I_CMD_DATA == ALL_ONES);

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      state <= ST_OFF;
      cnt <= '0;
      wait_tgt <= '0;
      retry <= 2'h0;
      op <= OP_POLL;
      use_poll <= 1'b0;
      shift_start <= 1'b0;
      shift_tx <= '0;
      O_DEV_RESET <= 1'b0;
      O_DONE <= 1'b0;
      O_REFUSED <= 1'b0;
      O_SYNCED <= 1'b0;
      O_SYNC_FAIL <= 1'b0;
    end
    else
    begin
      shift_start <= 1'b0;
      O_DONE <= 1'b0;
      O_REFUSED <= 1'b0;
      case (state)
        ST_OFF:
        begin
          if (I_SESSION && !O_SYNC_FAIL)
          begin
            state <= ST_RST_PULSE;
            O_DEV_RESET <= 1'b1;
            cnt <= '0;
          end
        end
        ST_RST_PULSE:
        begin
          // sck is low here, so the pulse resynchronises the port
          cnt <= cnt + 1'b1;
          if (cnt == WAIT_W'(RST_PULSE_CYC - 1))
          begin
            O_DEV_RESET <= 1'b0;
            cnt <= '0;
            state <= ST_POWERUP;
          end
        end
        ST_POWERUP:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == WAIT_W'(POWERUP_CYC - 1))
          begin
            shift_tx <= {OPC_ENABLE, ENABLE_ECHO, 16'h0};
            shift_start <= 1'b1;
            state <= ST_ENABLE;
          end
        end
        ST_ENABLE:
        begin
          // all four bytes go out before the echo is judged
          if (shift_done)
          begin
            if (shift_rx[ECHO_LSB +: 8] == ENABLE_ECHO)
            begin
              O_SYNCED <= 1'b1;
              retry <= 2'h0;
              state <= ST_IDLE;
            end
            else if (retry == 2'(RETRY_MAX - 1))
            begin
              O_SYNC_FAIL <= 1'b1;
              O_DEV_RESET <= 1'b1;
              state <= ST_OFF;
            end
            else
            begin
              retry <= retry + 2'h1;
              O_DEV_RESET <= 1'b1;
              cnt <= '0;
              state <= ST_RST_PULSE;
            end
          end
        end
        ST_IDLE:
        begin
          if (!I_SESSION)
          begin
            O_DEV_RESET <= 1'b1;
            O_SYNCED <= 1'b0;
            state <= ST_OFF;
          end
          else if (accept && refuse)
          begin
            O_REFUSED <= 1'b1;
          end
          else if (accept && skip)
          begin
            O_DONE <= 1'b1;
          end
          else if (accept)
          begin
            op <= I_CMD_OP;
            // polling cannot see completion of an all-ones page
            use_poll <= I_CMD_POLL &&
                        !(I_CMD_OP == OP_WRITE_PAGE && page_ones);
            shift_tx <= encode(I_CMD_OP, I_CMD_HIGH, I_CMD_ADDR, I_CMD_DATA);
            shift_start <= 1'b1;
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (shift_done)
          begin
            cnt <= '0;
            if (op == OP_WRITE_PAGE || op == OP_WRITE_EE || op == OP_ERASE)
            begin
              if (use_poll)
              begin
                shift_tx <= {OPC_POLL, 24'h0};
                shift_start <= 1'b1;
                state <= ST_POLL;
              end
              else
              begin
                state <= ST_WAIT;
              end
              if (op == OP_WRITE_PAGE)
                wait_tgt <= WAIT_W'(FLASH_CYC - 1);
              else if (op == OP_WRITE_EE)
                wait_tgt <= WAIT_W'(EEPROM_CYC - 1);
              else
                wait_tgt <= WAIT_W'(ERASE_CYC - 1);
            end
            else
            begin
              O_DONE <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        ST_POLL:
        begin
          // polls are bounded by the timed wait as a fallback
          cnt <= cnt + 1'b1;
          if (shift_done)
          begin
            if (!shift_rx[POLL_BUSY_BIT] || cnt >= wait_tgt)
            begin
              O_DONE <= 1'b1;
              state <= ST_IDLE;
            end
            else
            begin
              shift_start <= 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == wait_tgt)
          begin
            O_DONE <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // read data
  // --------------------------------------------------------------
  // the device returns all ones while its page programs
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      O_RDATA <= 8'h0;
    else if (state == ST_SHIFT && shift_done)
      O_RDATA <= shift_rx[7:0];
  end

  // --------------------------------------------------------------
  // page and erase bookkeeping
  // --------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      erased <= 1'b0;
      low_loaded <= 1'b0;
      low_addr <= '0;
      page_ones <= 1'b1;
    end
    else if (state == ST_OFF)
    begin
      low_loaded <= 1'b0;
      page_ones <= 1'b1;
    end
    else if (accept && !refuse && !skip)
    begin
      if (I_CMD_OP == OP_ERASE)
        erased <= 1'b1;
      if (I_CMD_OP == OP_LOAD_PAGE)
      begin
        low_loaded <= !I_CMD_HIGH;
        low_addr <= I_CMD_ADDR[PAGE_WORD_W-1:0];
        if (I_CMD_DATA != ALL_ONES)
          page_ones <= 1'b0;
      end
      if (I_CMD_OP == OP_WRITE_PAGE)
      begin
        page_ones <= 1'b1;
        low_loaded <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  int unsigned sck_run;
  int unsigned since_low;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      sck_run <= 0;
      since_low <= 0;
    end
    else
    begin
      sck_run <= ($changed(O_SCK)) ? 1 : sck_run + 1;
      since_low <= (O_DEV_RESET) ? 0 : since_low + 1;
    end
  end

  property p_reset_low_in_session;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    (state == ST_SHIFT || state == ST_POLL || state == ST_WAIT) |-> !O_DEV_RESET;
  endproperty
  a_reset_low_in_session: assert property (p_reset_low_in_session)
    else $error("target reset high during a programming session");

  property p_enable_first;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    shift_start && shift_tx[31:16] != {OPC_ENABLE, ENABLE_ECHO} |-> O_SYNCED;
  endproperty
  a_enable_first: assert property (p_enable_first)
    else $error("instruction sent before programming enable");

  property p_sck_phase;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    $changed(O_SCK) |-> sck_run >= SCK_HALF;
  endproperty
  a_sck_phase: assert property (p_sck_phase)
    else $error("serial clock phase too short");

  property p_mosi_at_rise;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    $rose(O_SCK) |-> $stable(O_MOSI) ##1 $stable(O_MOSI);
  endproperty
  a_mosi_at_rise: assert property (p_mosi_at_rise)
    else $error("mosi moved around a serial clock rise");

  property p_reset_pulse;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    $rose(O_DEV_RESET) && state != ST_IDLE |-> !O_SCK;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset pulsed while serial clock high");

  property p_powerup_wait;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    // start strobe is registered, so it is seen once the state has moved on
    shift_start && state == ST_ENABLE |-> since_low >= POWERUP_CYC;
  endproperty
  a_powerup_wait: assert property (p_powerup_wait)
    else $error("enable sent before the power-up wait");

  property p_bad_echo_resync;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_ENABLE && shift_done && shift_rx[15:8] != ENABLE_ECHO |=> O_DEV_RESET;
  endproperty
  a_bad_echo_resync: assert property (p_bad_echo_resync)
    else $error("missing echo did not pulse target reset");

  property p_session_end;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_IDLE && !I_SESSION |=> O_DEV_RESET && !O_CMD_READY;
  endproperty
  a_session_end: assert property (p_session_end)
    else $error("session end did not release target reset");

  property p_wait_holds;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_WAIT |-> !shift_busy && !shift_start;
  endproperty
  a_wait_holds: assert property (p_wait_holds)
    else $error("serial port accessed during a write wait");

  property p_high_refused;
    @(posedge I_CLK_SYS) disable iff (I_RST)
    accept && refuse |=> O_REFUSED && state == ST_IDLE;
  endproperty
  a_high_refused: assert property (p_high_refused)
    else $error("high byte load accepted without low byte");

  c_synced: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) $rose(O_SYNCED));
  c_poll: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_POLL ##1 O_DONE);
  c_retry: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_ENABLE ##1 state == ST_RST_PULSE);
  c_page: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
    state == ST_WAIT && op == OP_WRITE_PAGE ##1 O_DONE);

endmodule
`default_nettype wire

// [src/isp_shifter.sv]
// four-byte serial shifter, serial clock divided from the system clock
`timescale 1ns/1ps
`default_nettype none
module isp_shifter #(
  parameter int HALF = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // word request
  input wire logic i_start,
  input wire logic [31:0] i_tx,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_rx,
  // link pins
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi
);
  logic [15:0] half_cnt;
  logic [4:0] bit_cnt;
  logic [31:0] sr;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_sck <= 1'b0;
      o_mosi <= 1'b0;
      o_rx <= 32'h0;
      sr <= 32'h0;
      half_cnt <= 16'h0;
      bit_cnt <= 5'h0;
    end
    else
    begin
      o_done <= 1'b0;
      if (!o_busy)
      begin
        if (i_start)
        begin
          o_busy <= 1'b1;
          sr <= i_tx;
          o_mosi <= i_tx[31];
          half_cnt <= 16'h0;
          bit_cnt <= 5'h0;
        end
      end
      else if (half_cnt == 16'(HALF - 1))
      begin
        half_cnt <= 16'h0;
        if (!o_sck)
        begin
          // device takes mosi on this rise
          o_sck <= 1'b1;
        end
        else
        begin
          // miso moved on the last fall, sample late in the high phase
          o_rx <= {o_rx[30:0], i_miso};
          o_sck <= 1'b0;
          if (bit_cnt == 5'h1f)
          begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end
          else
          begin
            bit_cnt <= bit_cnt + 5'h1;
            sr <= {sr[30:0], 1'b0};
            o_mosi <= sr[30];
          end
        end
      end
      else
      begin
        half_cnt <= half_cnt + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [src/isp_sync.sv]
// two-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module isp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic meta;
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          meta <= 1'b0;
          o_q[g] <= 1'b0;
        end
        else
        begin
          meta <= i_d[g];
          o_q[g] <= meta;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [tb/isp_target_model.sv]
// behavioural model of the programmed device on the serial link
`timescale 1ns/1ps
`default_nettype none
module isp_target_model
  import isp_pkg::*;
#(
  parameter realtime CPU_NS = 125.0,
  parameter realtime PWR_NS = 1000.0,
  parameter realtime BUSY_NS = 5000.0
) (
  // target pins
  input wire logic i_dev_reset,
  input wire logic i_sck,
  input wire logic i_mosi,
  output logic o_miso,
  // fault control and status
  input wire logic i_bad_echo,
  output logic [7:0] o_err_cnt
);
  logic [7:0] fl [0:16383];
  logic [7:0] ee [0:1023];
  logic [7:0] pbuf [0:127];
  logic [31:0] rx = 32'h0;
  logic [7:0] sh = 8'h0;
  logic q = 1'b0;
  logic sync = 1'b0;
  int cnt = 0;
  realtime t_edge = -1.0e9;
  realtime t_rst = -1.0e9;
  realtime t_busy = 0.0;
  initial
  begin
    o_err_cnt = 8'h00;
    foreach (fl[i]) fl[i] = 8'h5a;
    foreach (ee[i]) ee[i] = 8'h5a;
    foreach (pbuf[i]) pbuf[i] = 8'hff;
  end
  // released pin flips so a stale level never passes as data
  assign o_miso = i_dev_reset ? ~q : q;
  function automatic logic busy();
    return $realtime < t_busy;
  endfunction
  function automatic logic [7:0] reply();
    if (rx[23:16] == OPC_POLL) return {7'h00, busy()};
    if (busy()) return 8'hff;
    if (rx[23:20] == OPC_READ_FLASH) return fl[{rx[12:0], rx[19]}];
    if (rx[23:16] == OPC_READ_EE) return ee[rx[9:0]];
    return 8'ha5;
  endfunction
  task automatic execute();
    if (rx[31:16] == {OPC_ENABLE, ENABLE_ECHO})
      sync = !i_bad_echo;
    else if (!sync || (rx[31:24] != OPC_POLL && busy()))
      o_err_cnt++;
    else if (rx[31:24] == OPC_ENABLE && rx[23:21] == 3'b100)
    begin
      foreach (fl[i]) fl[i] = 8'hff;
      foreach (ee[i]) ee[i] = 8'hff;
      t_busy = $realtime + 2 * BUSY_NS;
    end
    else if (rx[31:24] == OPC_WRITE_PAGE)
    begin
      for (int i = 0; i < 128; i++) fl[{rx[20:14], i[6:0]}] = pbuf[i];
      t_busy = $realtime + BUSY_NS;
    end
    else if (rx[31:28] == OPC_LOAD_PAGE)
      pbuf[{rx[13:8], rx[27]}] = rx[7:0];
    else if (rx[31:24] == OPC_WRITE_EE)
    begin
      ee[rx[17:8]] = rx[7:0];
      t_busy = $realtime + BUSY_NS;
    end
  endtask
  // ----------------------------------------
  // pin timing and shifting
  // ----------------------------------------
  always @(posedge i_dev_reset)
  begin
    t_rst = $realtime;
    sync = 1'b0;
    cnt = 0;
  end
  always @(negedge i_dev_reset)
  begin
    if ($realtime - t_rst < 2 * CPU_NS) o_err_cnt++;
    t_rst = $realtime;
  end
  always @(i_sck)
  begin
    if (!i_dev_reset && $realtime - t_edge <= 2 * CPU_NS) o_err_cnt++;
    t_edge = $realtime;
  end
  always @(posedge i_sck)
  begin
    if (!i_dev_reset)
    begin
      if (!sync && cnt == 0 && $realtime - t_rst < PWR_NS) o_err_cnt++;
      rx = {rx[30:0], i_mosi};
      cnt = cnt + 1;
      if (cnt == 32)
      begin
        cnt = 0;
        execute();
      end
    end
  end
  always @(negedge i_sck)
  begin
    if (cnt % 8 == 0)
      sh = (cnt == 16) ? rx[7:0] ^ {8{i_bad_echo}} : (cnt == 24) ? reply() : ~sh;
    q <= sh[7];
    sh = {sh[6:0], 1'b0};
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the programming host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import isp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic session = 1'b0;
  logic valid = 1'b0;
  isp_op_t op = OP_POLL;
  logic high = 1'b0;
  logic poll = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic bad_echo = 1'b0;
  logic ready, done, refused, synced, sync_fail, dev_reset, sck, mosi, miso;
  logic [7:0] rdata;
  logic [7:0] err_cnt;
  logic got_done, got_ref;
  int lat;
  int fail_count = 0;
  int n_tests = 0;
  isp_programmer #(.POWERUP_CYC(200), .FLASH_CYC(4000), .EEPROM_CYC(2000),
    .ERASE_CYC(3000)) isp_programmer_i (.I_CLK_SYS(clk), .I_RST(rst),
    .I_SESSION(session), .I_CMD_VALID(valid), .I_CMD_OP(op), .I_CMD_HIGH(high),
    .I_CMD_POLL(poll), .I_CMD_ADDR(addr), .I_CMD_DATA(wdata), .O_CMD_READY(ready),
    .O_DONE(done), .O_REFUSED(refused), .O_RDATA(rdata), .O_SYNCED(synced),
    .O_SYNC_FAIL(sync_fail), .O_DEV_RESET(dev_reset), .O_SCK(sck), .O_MOSI(mosi),
    .I_MISO(miso));
  isp_target_model isp_target_model_i (.i_dev_reset(dev_reset), .i_sck(sck),
    .i_mosi(mosi), .o_miso(miso), .i_bad_echo(bad_echo), .o_err_cnt(err_cnt));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d, compares %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // command driver and scenarios
  // ----------------------------------------
  task automatic cmd(input isp_op_t o, input logic h, input logic p,
    input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    op <= o;
    high <= h;
    poll <= p;
    addr <= a;
    wdata <= d;
    valid <= 1'b1;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    valid <= 1'b0;
    got_done = 1'b0;
    got_ref = 1'b0;
    for (lat = 1; lat < 40000 && !got_done && !got_ref; lat++)
    begin
      @(negedge clk);
      got_done = done;
      got_ref = refused;
    end
  endtask
  task automatic t_sync_fail();
    @(posedge clk);
    bad_echo <= 1'b1;
    session <= 1'b1;
    for (int i = 0; i < 30000 && sync_fail !== 1'b1; i++) @(negedge clk);
    chk(sync_fail, 8'h01);
    chk(synced, 8'h00);
    chk(dev_reset, 8'h01);
    // target reset pulse must outlast two cpu cycles before reset drops it
    repeat (60) @(posedge clk);
    rst <= 1'b1;
    bad_echo <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic t_session();
    for (int i = 0; i < 8000 && synced !== 1'b1; i++) @(negedge clk);
    chk(synced, 8'h01);
    chk(dev_reset, 8'h00);
    chk(ready, 8'h01);
  endtask
  task automatic t_erase();
    cmd(OP_ERASE, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk(got_done, 8'h01);
    cmd(OP_READ_FLASH, 1'b0, 1'b0, 16'h0041, 8'h00);
    chk(rdata, 8'hff);
  endtask
  task automatic t_flash();
    cmd(OP_LOAD_PAGE, 1'b1, 1'b0, 16'h0042, 8'h77);
    chk(got_ref, 8'h01);
    cmd(OP_LOAD_PAGE, 1'b0, 1'b0, 16'h0041, 8'h12);
    cmd(OP_LOAD_PAGE, 1'b1, 1'b0, 16'h0041, 8'h34);
    chk(got_done, 8'h01);
    cmd(OP_WRITE_PAGE, 1'b0, 1'b1, 16'h0041, 8'h00);
    chk(got_done, 8'h01);
    cmd(OP_READ_FLASH, 1'b0, 1'b0, 16'h0041, 8'h00);
    chk(rdata, 8'h12);
    cmd(OP_READ_FLASH, 1'b1, 1'b0, 16'h0041, 8'h00);
    chk(rdata, 8'h34);
  endtask
  task automatic t_eeprom();
    cmd(OP_WRITE_EE, 1'b0, 1'b0, 16'h03c3, 8'ha5);
    chk(got_done, 8'h01);
    cmd(OP_WRITE_EE, 1'b0, 1'b0, 16'h0011, 8'hff);
    chk(lat <= 3, 8'h01);
    cmd(OP_READ_EE, 1'b0, 1'b0, 16'h03c3, 8'h00);
    chk(rdata, 8'ha5);
    cmd(OP_POLL, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk(rdata, 8'h00);
  endtask
  task automatic t_end();
    @(posedge clk);
    session <= 1'b0;
    for (int i = 0; i < 100 && dev_reset !== 1'b1; i++) @(negedge clk);
    chk(dev_reset, 8'h01);
    chk(synced, 8'h00);
    chk(err_cnt, 8'h00);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_sync_fail();
    t_session();
    t_erase();
    t_flash();
    t_eeprom();
    t_end();
    complete_run();
  end
  // hang guard, well past the expected run
  initial
  begin
    repeat (95000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
